// >>> bench/csrg_card_model.sv
// Behavioural card contacts on the far side of the gate
`timescale 1ns/1ps
`default_nettype none
module csrg_card_model (
  // Card pull requests and gate enables, bit 0 io, 1 aux a, 2 aux b
  input  wire logic [2:0] pull_low,
  input  wire logic [2:0] gate_oe_n,
  // Resolved contact levels
  output var  logic [2:0] line
);
  // Pull-up wins once both parties release, so no stale level lingers
  always_comb begin
    line = gate_oe_n & ~pull_low;
  end
endmodule
`default_nettype wire

// >>> bench/csrg_props.sv
// Port-level checks of the card routing gate
`timescale 1ns/1ps
`default_nettype none
module csrg_props (
  // Clock and controls
  input wire logic                clk,
  input wire logic                rstn,
  input wire logic                card_mode_sel,
  input wire logic                chip_sel,
  input wire logic                power_down,
  input wire logic                supply_sel_a,
  input wire logic                supply_sel_b,
  input wire logic                host_reset_in,
  input wire logic                host_clock_in,
  input wire logic                card_inserted,
  input wire logic                irq_ack,
  // Outputs and line levels
  input wire logic                card_supply_en,
  input wire csrg_pkg::csrg_sel_t card_supply_level,
  input wire logic                card_reset_out,
  input wire logic                card_reset_oe_n,
  input wire logic                card_clk_out,
  input wire logic                card_clk_oe_n,
  input wire logic                card_io_oe_n,
  input wire logic                card_aux_a_in,
  input wire logic                card_aux_a_oe_n,
  input wire logic                host_io_in,
  input wire logic                host_io_oe_n,
  input wire logic                host_aux_a_oe_n,
  input wire logic                host_aux_b_oe_n,
  input wire logic                usb_plus_line_in,
  input wire logic                usb_plus_line_oe_n,
  input wire logic                usb_minus_line_oe_n,
  input wire logic                ready_flag_oe_n,
  input wire logic                ready_pu_en,
  input wire logic                fault_irq_n_oe_n,
  input wire logic                fault_pu_en
);
  import csrg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // USB plus line falls while the bridge has been idle in USB mode
  sequence s_usb_fall;
    !card_mode_sel && !$past(card_mode_sel) && $fell(usb_plus_line_in)
      && card_aux_a_in && $past(card_aux_a_in);
  endsequence
  sequence s_card_inserted_edge;
    chip_sel && !irq_ack && $changed(card_inserted);
  endsequence
  AST_CLK_COPY: assert property (card_clk_out |-> $past(host_clock_in))
    else $error("card clock high without host clock");
  AST_RST_COPY: assert property (($past(chip_sel) && card_reset_out)
    |-> $past(host_reset_in)) else $error("card reset not a copy");
  AST_OFF_LOW: assert property (!card_supply_en [*2]
    |-> !card_reset_out && !card_clk_out) else $error("outputs high unpowered");
  AST_MODE_LOW: assert property (!card_mode_sel |=> card_clk_oe_n
    && card_reset_oe_n && card_io_oe_n && host_aux_a_oe_n && host_aux_b_oe_n)
    else $error("card lines driven in usb mode");
  AST_MODE_HIGH: assert property (card_mode_sel |=> !card_clk_oe_n
    && !card_reset_oe_n && usb_plus_line_oe_n && usb_minus_line_oe_n)
    else $error("card mode routing wrong");
  AST_USB_BRIDGE: assert property (s_usb_fall |=> !card_aux_a_oe_n)
    else $error("usb plus not forwarded");
  AST_DESELECT: assert property (!chip_sel |=> host_io_oe_n
    && host_aux_a_oe_n && host_aux_b_oe_n && ready_flag_oe_n
    && fault_irq_n_oe_n && !ready_pu_en) else $error("deselect not honoured");
  AST_FAULT_PU: assert property ((!chip_sel || power_down) |=> !fault_pu_en)
    else $error("fault pull-up left on");
  AST_PRESENT: assert property ($rose(card_supply_en) |-> $past(card_inserted))
    else $error("supply on without card");
  AST_LEVEL: assert property (($rose(card_supply_en) && $past(chip_sel))
    |-> card_supply_level == {$past(supply_sel_a), $past(supply_sel_b)})
    else $error("supply level decode wrong");
  AST_IO_RELEASE: assert property ((!card_io_oe_n && host_io_in) |=> card_io_oe_n)
    else $error("card io held after host release");
  AST_CARD_INSERTED_IRQ: assert property (s_card_inserted_edge ##1 (chip_sel && !irq_ack)
    |-> ##[0:1] !fault_irq_n_oe_n) else $error("presence change not flagged");
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the card routing gate
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csrg_pkg::*;
  logic clk, rstn, card_mode_sel, chip_sel, power_down, supply_sel_a;
  logic supply_sel_b, host_reset_in, host_clock_in, card_inserted;
  logic irq_ack, supply_ok;
  logic [2:0] host_pull, card_pull;
  logic [1:0] usb_pull;
  int         fail_count, tests_run, cycles;
  wire logic card_supply_en, card_reset_out, card_reset_oe_n, card_clk_out,
    card_clk_oe_n, card_io_oe_n, card_aux_a_oe_n, card_aux_b_oe_n,
    host_io_oe_n, host_aux_a_oe_n, host_aux_b_oe_n, usb_plus_line_oe_n,
    usb_minus_line_oe_n, ready_flag_oe_n, ready_pu_en, fault_irq_n_oe_n,
    fault_pu_en, card_pullup_en;
  wire csrg_sel_t  card_supply_level;
  wire logic [2:0] card_line;
  wire logic card_io_in = card_line[0];
  wire logic card_aux_a_in = card_line[1];
  wire logic card_aux_b_in = card_line[2];
  wire logic host_io_in = host_io_oe_n & ~host_pull[0];
  wire logic host_aux_a_in = host_aux_a_oe_n & ~host_pull[1];
  wire logic host_aux_b_in = host_aux_b_oe_n & ~host_pull[2];
  wire logic usb_plus_line_in = usb_plus_line_oe_n & ~usb_pull[0];
  wire logic usb_minus_line_in = usb_minus_line_oe_n & ~usb_pull[1];
  csrg_gate #(.RAMP_TMO_CYC(16)) dut (.clk, .rstn, .card_mode_sel,
    .chip_sel, .power_down, .supply_sel_a, .supply_sel_b, .host_reset_in,
    .host_clock_in, .card_inserted, .irq_ack, .supply_ok, .card_supply_en,
    .card_supply_level, .card_reset_out, .card_reset_oe_n, .card_clk_out,
    .card_clk_oe_n, .card_io_in, .card_io_out(), .card_io_oe_n,
    .card_aux_a_in, .card_aux_a_out(), .card_aux_a_oe_n, .card_aux_b_in,
    .card_aux_b_out(), .card_aux_b_oe_n, .card_pullup_en, .host_io_in,
    .host_io_out(), .host_io_oe_n, .host_aux_a_in, .host_aux_a_out(),
    .host_aux_a_oe_n, .host_aux_b_in, .host_aux_b_out(), .host_aux_b_oe_n,
    .usb_plus_line_in, .usb_plus_line_out(), .usb_plus_line_oe_n,
    .usb_minus_line_in, .usb_minus_line_out(), .usb_minus_line_oe_n,
    .ready_flag_out(), .ready_flag_oe_n, .ready_pu_en, .fault_irq_n_out(),
    .fault_irq_n_oe_n, .fault_pu_en);
  csrg_card_model card (.pull_low(card_pull), .line(card_line),
    .gate_oe_n({card_aux_b_oe_n, card_aux_a_oe_n, card_io_oe_n}));
  // ******************************
  // Helpers
  // ******************************
  always #25 clk = ~clk;
  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [1:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Long enough for the sequence below with ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      stop_test();
    end
  end
  // ******************************
  // Sequence
  // ******************************
  initial begin
    {clk, rstn, power_down, supply_ok, irq_ack, card_inserted} = '0;
    {card_mode_sel, chip_sel, supply_sel_a, supply_sel_b} = 4'hf;
    {host_reset_in, host_clock_in} = '0;
    {host_pull, card_pull, usb_pull} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    go(1);
    check("level", card_supply_level, 2'h3);
    @(posedge clk);
    supply_sel_a <= 1'h0;
    go(4);
    check("supply no card", card_supply_en, 1'h0);
    @(posedge clk);
    supply_sel_a <= 1'h1;
    card_inserted <= 1'h1;
    go(3);
    check("presence irq", fault_irq_n_oe_n, 1'h0);
    @(posedge clk);
    irq_ack <= 1'h1;
    @(posedge clk);
    irq_ack <= 1'h0;
    go(2);
    check("irq cleared", fault_irq_n_oe_n, 1'h1);
    @(posedge clk);
    supply_ok <= 1'h1;
    supply_sel_a <= 1'h0;
    go(2);
    check("supply on", card_supply_en, 1'h1);
    check("level 5v0", card_supply_level, 2'h1);
    @(posedge clk);
    host_reset_in <= 1'h1;
    host_clock_in <= 1'h1;
    go(4);
    check("reset copy", card_reset_out, 1'h1);
    check("clock copy", card_clk_out, 1'h1);
    @(posedge clk);
    host_clock_in <= 1'h0;
    chip_sel <= 1'h0;
    @(posedge clk);
    host_reset_in <= 1'h0;
    supply_sel_a <= 1'h1;
    supply_sel_b <= 1'h1;
    host_pull[0] <= 1'h1;
    go(3);
    check("clock low", card_clk_out, 1'h0);
    check("reset latched", card_reset_out, 1'h1);
    check("supply latched", card_supply_en, 1'h1);
    check("ready pull-up", ready_pu_en, 1'h0);
    check("ready released", ready_flag_oe_n, 1'h1);
    check("fault pull-up", fault_pu_en, 1'h0);
    check("io isolated", card_io_in, 1'h1);
    @(posedge clk);
    chip_sel <= 1'h1;
    go(3);
    check("supply off", card_supply_en, 1'h0);
    check("io to card", card_io_in, 1'h0);
    @(posedge clk);
    host_pull[0] <= 1'h0;
    go(3);
    check("io released", card_io_in, 1'h1);
    @(posedge clk);
    card_pull[0] <= 1'h1;
    go(2);
    check("io to host", host_io_in, 1'h0);
    @(posedge clk);
    card_pull[0] <= 1'h0;
    supply_sel_a <= 1'h0;
    host_reset_in <= 1'h1;
    go(6);
    check("reset again", card_reset_out, 1'h1);
    @(posedge clk);
    supply_ok <= 1'h0;
    go(3);
    check("reset dropped", card_reset_out, 1'h0);
    check("supply fault", card_supply_en, 1'h0);
    check("fault irq", fault_irq_n_oe_n, 1'h0);
    @(posedge clk);
    power_down <= 1'h1;
    go(2);
    check("pull-up down", fault_pu_en, 1'h0);
    @(posedge clk);
    power_down <= 1'h0;
    supply_sel_a <= 1'h1;
    card_mode_sel <= 1'h0;
    go(3);
    check("clk tristate", card_clk_oe_n, 1'h1);
    check("rst tristate", card_reset_oe_n, 1'h1);
    check("card pull-up", card_pullup_en, 1'h0);
    @(posedge clk);
    usb_pull <= 2'h1;
    go(2);
    check("usb plus", card_aux_a_in, 1'h0);
    @(posedge clk);
    usb_pull <= 2'h2;
    go(4);
    check("usb minus", card_aux_b_in, 1'h0);
    check("plus freed", card_aux_a_in, 1'h1);
    @(posedge clk);
    usb_pull <= 2'h0;
    host_pull[1] <= 1'h1;
    go(3);
    check("host aux open", card_aux_a_in, 1'h1);
    // The card may only pull once the lane has gone idle again
    @(posedge clk);
    card_pull[2] <= 1'h1;
    go(3);
    check("card to minus", usb_minus_line_in, 1'h0);
    @(posedge clk);
    {host_pull, card_pull} <= '0;
    card_mode_sel <= 1'h1;
    go(3);
    check("clk driven", card_clk_oe_n, 1'h0);
    @(posedge clk);
    card_pull[1] <= 1'h1;
    go(3);
    check("plus isolated", usb_plus_line_in, 1'h1);
    check("aux to host", host_aux_a_in, 1'h0);
    @(posedge clk);
    supply_ok <= 1'h0;
    supply_sel_a <= 1'h0;
    go(4);
    check("ramping", card_supply_en, 1'h1);
    go(16);
    check("ramp timeout", card_supply_en, 1'h0);
    check("timeout irq", fault_irq_n_oe_n, 1'h0);
    stop_test();
  end
endmodule
bind csrg_gate csrg_props u_props (.clk, .rstn, .card_mode_sel, .chip_sel,
  .power_down, .supply_sel_a, .supply_sel_b, .host_reset_in, .host_clock_in,
  .card_inserted, .irq_ack, .card_supply_en, .card_supply_level,
  .card_reset_out, .card_reset_oe_n, .card_clk_out, .card_clk_oe_n,
  .card_io_oe_n, .card_aux_a_in, .card_aux_a_oe_n, .host_io_in,
  .host_io_oe_n, .host_aux_a_oe_n, .host_aux_b_oe_n, .usb_plus_line_in,
  .usb_plus_line_oe_n, .usb_minus_line_oe_n, .ready_flag_oe_n, .ready_pu_en,
  .fault_irq_n_oe_n, .fault_pu_en);
`default_nettype wire

// >>> rtl/csrg_gate.sv
// Card signal routing gate: mode routing, supply sequencing, gating
`include "csrg_params.svh"
`timescale 1ns/1ps
`default_nettype none

module csrg_gate #(
  parameter int RAMP_TMO_CYC = `CSRG_RAMP_TMO_CYC
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Mode and chip select
  input  wire logic         card_mode_sel,
  input  wire logic         chip_sel,
  input  wire logic         power_down,
  // Host control inputs
  input  wire logic         supply_sel_a,
  input  wire logic         supply_sel_b,
  input  wire logic         host_reset_in,
  input  wire logic         host_clock_in,
  input  wire logic         card_inserted,
  input  wire logic         irq_ack,
  // Analog supply status and control
  input  wire logic         supply_ok,
  output var  logic         card_supply_en,
  output var  csrg_pkg::csrg_sel_t card_supply_level,
  // Card reset and clock
  output var  logic         card_reset_out,
  output var  logic         card_reset_oe_n,
  output var  logic         card_clk_out,
  output var  logic         card_clk_oe_n,
  // Card data lines
  input  wire logic         card_io_in,
  output var  logic         card_io_out,
  output var  logic         card_io_oe_n,
  input  wire logic         card_aux_a_in,
  output var  logic         card_aux_a_out,
  output var  logic         card_aux_a_oe_n,
  input  wire logic         card_aux_b_in,
  output var  logic         card_aux_b_out,
  output var  logic         card_aux_b_oe_n,
  output var  logic         card_pullup_en,
  // Host data lines
  input  wire logic         host_io_in,
  output var  logic         host_io_out,
  output var  logic         host_io_oe_n,
  input  wire logic         host_aux_a_in,
  output var  logic         host_aux_a_out,
  output var  logic         host_aux_a_oe_n,
  input  wire logic         host_aux_b_in,
  output var  logic         host_aux_b_out,
  output var  logic         host_aux_b_oe_n,
  // USB lines
  input  wire logic         usb_plus_line_in,
  output var  logic         usb_plus_line_out,
  output var  logic         usb_plus_line_oe_n,
  input  wire logic         usb_minus_line_in,
  output var  logic         usb_minus_line_out,
  output var  logic         usb_minus_line_oe_n,
  // Open-drain status lines
  output var  logic         ready_flag_out,
  output var  logic         ready_flag_oe_n,
  output var  logic         ready_pu_en,
  output var  logic         fault_irq_n_out,
  output var  logic         fault_irq_n_oe_n,
  output var  logic         fault_pu_en
);
  import csrg_pkg::*;

  localparam int NL = `CSRG_NLANES;

  // ****************************************************************
  // Lane next-state
  // ****************************************************************
  // x is the card side, y the host or USB side; low means driven.
  function automatic csrg_lane_t lane_nxt(
    input csrg_lane_t st,
    input logic       en,
    input logic       x,
    input logic       y
  );
    csrg_lane_t n;
    n = st;
    if (!en) begin
      n = LANE_IDLE;
    end else begin
      case (st)
        LANE_IDLE: begin
          if (!x) begin
            n = LANE_CARD;
          end else if (!y) begin
            n = LANE_FAR;
          end
        end
        LANE_CARD: begin
          if (x) begin
            n = LANE_REL;
          end
        end
        LANE_FAR: begin
          if (y) begin
            n = LANE_REL;
          end
        end
        LANE_REL: begin
          // Both ends must read high again, or our own echo retriggers
          if (x && y) begin
            n = LANE_IDLE;
          end
        end
        default: n = LANE_IDLE;
      endcase
    end
    return n;
  endfunction

  // ****************************************************************
  // Chip select latching
  // ****************************************************************
  csrg_sel_t sel_hold_ff;
  logic      rst_hold_ff;
  csrg_sel_t sel_eff;
  logic      rst_eff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_hold_ff <= `CSRG_RST_SEL;
      rst_hold_ff <= `CSRG_RST_BIT;
    end else if (chip_sel) begin
      sel_hold_ff <= {supply_sel_a, supply_sel_b};
      rst_hold_ff <= host_reset_in;
    end
  end

  // Deselected, the values seen at the fall are held
  always_comb begin
    if (chip_sel) begin
      sel_eff = {supply_sel_a, supply_sel_b};
      rst_eff = host_reset_in;
    end else begin
      sel_eff = sel_hold_ff;
      rst_eff = rst_hold_ff;
    end
  end

  // ****************************************************************
  // Card supply sequencer
  // ****************************************************************
  csrg_seq_t             seq_ff;
  csrg_seq_t             nxt_seq;
  logic [`CSRG_TMR_W-1:0] tmr_ff;
  logic                  want_on;
  logic                  tmr_done;

  assign want_on  = (sel_eff != `CSRG_SEL_OFF) && !power_down;
  assign tmr_done = tmr_ff ==
                    `CSRG_TMR_W'(RAMP_TMO_CYC - 1);

  always_comb begin
    nxt_seq = seq_ff;
    case (seq_ff)
      SEQ_IDLE: begin
        if (want_on && card_inserted) begin
          nxt_seq = SEQ_RAMP;
        end
      end
      SEQ_RAMP: begin
        if (!want_on || !card_inserted) begin
          nxt_seq = SEQ_IDLE;
        end else if (supply_ok) begin
          nxt_seq = SEQ_ACTIVE;
        end else if (tmr_done) begin
          nxt_seq = SEQ_FAULT;
        end
      end
      SEQ_ACTIVE: begin
        if (!want_on || !card_inserted) begin
          nxt_seq = SEQ_IDLE;
        end else if (!supply_ok) begin
          nxt_seq = SEQ_FAULT;
        end
      end
      SEQ_FAULT: begin
        // Host must command the supply off before a retry
        if (!want_on) begin
          nxt_seq = SEQ_IDLE;
        end
      end
      default: nxt_seq = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_ff <= SEQ_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_ff <= '0;
    end else if (seq_ff != SEQ_RAMP) begin
      tmr_ff <= '0;
    end else if (!tmr_done) begin
      tmr_ff <= tmr_ff + `CSRG_TMR_W'(1);
    end
  end

  // Level is taken at activation; a change needs a fresh cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      card_supply_en    <= `CSRG_RST_BIT;
      card_supply_level <= `CSRG_RST_SEL;
    end else begin
      card_supply_en <= (nxt_seq == SEQ_RAMP) ||
                        (nxt_seq == SEQ_ACTIVE);
      if (seq_ff == SEQ_IDLE) begin
        card_supply_level <= sel_eff;
      end
    end
  end

  // ****************************************************************
  // Card reset and clock
  // ****************************************************************
  logic card_live;

  assign card_live = (seq_ff == SEQ_ACTIVE) && supply_ok;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      card_reset_out  <= `CSRG_RST_BIT;
      card_clk_out    <= `CSRG_RST_BIT;
      card_reset_oe_n <= `CSRG_RST_HIZ;
      card_clk_oe_n   <= `CSRG_RST_HIZ;
      card_pullup_en  <= `CSRG_RST_BIT;
    end else begin
      card_reset_out  <= card_live & rst_eff;
      // Sampled copy: card clock is limited to half the core rate
      card_clk_out    <= card_live & host_clock_in;
      card_reset_oe_n <= !card_mode_sel;
      card_clk_oe_n   <= !card_mode_sel;
      card_pullup_en  <= card_mode_sel;
    end
  end

  // ****************************************************************
  // Data lanes
  // ****************************************************************
  csrg_lane_t      lane_ff [NL];
  csrg_lane_t      nxt_lane [NL];
  logic [NL-1:0]   lane_en;
  logic [NL-1:0]   x_in;
  logic [NL-1:0]   y_in;
  logic            mode_prev_ff;
  logic            host_on;

  // Host side passes only when selected and in card mode
  assign host_on = card_mode_sel && chip_sel;
  assign x_in = {card_aux_b_in, card_aux_a_in, card_io_in};

  always_comb begin
    if (card_mode_sel) begin
      y_in = {host_aux_b_in, host_aux_a_in, host_io_in};
    end else begin
      y_in = {usb_minus_line_in, usb_plus_line_in, 1'h1};
    end
    lane_en[`CSRG_LANE_IO]   = host_on;
    lane_en[`CSRG_LANE_AUXA] = host_on || !card_mode_sel;
    lane_en[`CSRG_LANE_AUXB] = host_on || !card_mode_sel;
    // A mode flip drops any transfer in flight
    if (mode_prev_ff != card_mode_sel) begin
      lane_en = '0;
    end
    for (int i = 0; i < NL; i++) begin
      nxt_lane[i] = lane_nxt(lane_ff[i], lane_en[i], x_in[i], y_in[i]);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_prev_ff <= `CSRG_RST_BIT;
      for (int i = 0; i < NL; i++) begin
        lane_ff[i] <= LANE_IDLE;
      end
    end else begin
      mode_prev_ff <= card_mode_sel;
      for (int i = 0; i < NL; i++) begin
        lane_ff[i] <= nxt_lane[i];
      end
    end
  end

  // ****************************************************************
  // Line drivers
  // ****************************************************************
  logic [NL-1:0] card_drv;
  logic [NL-1:0] far_drv;
  logic          usb_m;

  assign usb_m = !card_mode_sel;

  always_comb begin
    for (int i = 0; i < NL; i++) begin
      card_drv[i] = nxt_lane[i] == LANE_FAR;
      far_drv[i]  = nxt_lane[i] == LANE_CARD;
    end
  end

  // Every pass line only ever pulls low; high is the pull-up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      card_io_oe_n        <= `CSRG_RST_HIZ;
      card_aux_a_oe_n     <= `CSRG_RST_HIZ;
      card_aux_b_oe_n     <= `CSRG_RST_HIZ;
      host_io_oe_n        <= `CSRG_RST_HIZ;
      host_aux_a_oe_n     <= `CSRG_RST_HIZ;
      host_aux_b_oe_n     <= `CSRG_RST_HIZ;
      usb_plus_line_oe_n  <= `CSRG_RST_HIZ;
      usb_minus_line_oe_n <= `CSRG_RST_HIZ;
    end else begin
      card_io_oe_n    <= !card_drv[`CSRG_LANE_IO];
      card_aux_a_oe_n <= !card_drv[`CSRG_LANE_AUXA];
      card_aux_b_oe_n <= !card_drv[`CSRG_LANE_AUXB];
      host_io_oe_n    <= !(far_drv[`CSRG_LANE_IO] && host_on);
      host_aux_a_oe_n <=
        !(far_drv[`CSRG_LANE_AUXA] && host_on);
      host_aux_b_oe_n <=
        !(far_drv[`CSRG_LANE_AUXB] && host_on);
      usb_plus_line_oe_n <=
        !(far_drv[`CSRG_LANE_AUXA] && usb_m);
      usb_minus_line_oe_n <=
        !(far_drv[`CSRG_LANE_AUXB] && usb_m);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      card_io_out        <= `CSRG_RST_BIT;
      card_aux_a_out     <= `CSRG_RST_BIT;
      card_aux_b_out     <= `CSRG_RST_BIT;
      host_io_out        <= `CSRG_RST_BIT;
      host_aux_a_out     <= `CSRG_RST_BIT;
      host_aux_b_out     <= `CSRG_RST_BIT;
      usb_plus_line_out  <= `CSRG_RST_BIT;
      usb_minus_line_out <= `CSRG_RST_BIT;
      ready_flag_out     <= `CSRG_RST_BIT;
      fault_irq_n_out    <= `CSRG_RST_BIT;
    end
  end

  // ****************************************************************
  // Status and interrupt
  // ****************************************************************
  logic card_inserted_prev_ff;
  logic card_inserted_chg_ff;
  logic card_inserted_evt;
  logic fault_now;

  assign card_inserted_evt  = card_inserted_prev_ff != card_inserted;
  assign fault_now = nxt_seq == SEQ_FAULT;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      card_inserted_prev_ff <= `CSRG_RST_BIT;
    end else begin
      card_inserted_prev_ff <= card_inserted;
    end
  end

  // A new edge in the acknowledge cycle keeps the flag set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      card_inserted_chg_ff <= `CSRG_RST_BIT;
    end else if (card_inserted_evt) begin
      card_inserted_chg_ff <= 1'h1;
    end else if (irq_ack) begin
      card_inserted_chg_ff <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_flag_oe_n  <= `CSRG_RST_HIZ;
      fault_irq_n_oe_n <= `CSRG_RST_HIZ;
      ready_pu_en      <= `CSRG_RST_BIT;
      fault_pu_en      <= `CSRG_RST_BIT;
    end else begin
      ready_flag_oe_n  <=
        !(chip_sel && nxt_seq != SEQ_ACTIVE);
      fault_irq_n_oe_n <=
        !(chip_sel && (fault_now || card_inserted_chg_ff || card_inserted_evt));
      ready_pu_en      <= chip_sel && !power_down;
      fault_pu_en      <= chip_sel && !power_down;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/csrg_params.svh
// Constants for the card signal routing gate
`ifndef CSRG_PARAMS_SVH
`define CSRG_PARAMS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CSRG_CLK_MHZ        20
`define CSRG_RAMP_TMO_US    2000
`define CSRG_RAMP_TMO_CYC   (`CSRG_RAMP_TMO_US * `CSRG_CLK_MHZ)

// ****************************************************************
// Supply select decode, {supply_sel_a, supply_sel_b}
// ****************************************************************
`define CSRG_SEL_1V8        2'h0
`define CSRG_SEL_5V0        2'h1
`define CSRG_SEL_3V0        2'h2
`define CSRG_SEL_OFF        2'h3

// ****************************************************************
// Lane indices and reset values
// ****************************************************************
`define CSRG_LANE_IO        0
`define CSRG_LANE_AUXA      1
`define CSRG_LANE_AUXB      2
`define CSRG_NLANES         3
`define CSRG_RST_BIT        1'h0
`define CSRG_RST_HIZ        1'h1
`define CSRG_RST_SEL        2'h3
`define CSRG_TMR_W          20

`endif

// >>> rtl/csrg_pkg.sv
// Types shared by the card signal routing gate
package csrg_pkg;

  // ****************************************************************
  // Card supply sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    SEQ_IDLE   = 4'h1,
    SEQ_RAMP   = 4'h2,
    SEQ_ACTIVE = 4'h4,
    SEQ_FAULT  = 4'h8
  } csrg_seq_t;

  // ****************************************************************
  // Bidirectional lane states
  // ****************************************************************
  typedef enum logic [3:0] {
    LANE_IDLE = 4'h1,
    LANE_CARD = 4'h2,
    LANE_FAR  = 4'h4,
    LANE_REL  = 4'h8
  } csrg_lane_t;

  // Supply level code presented to the regulator
  typedef logic [1:0] csrg_sel_t;

endpackage
